// ==== design/ucss_core.sv ====
// two-channel uart with start/stop triggers, status and avalon-mm registers
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`include "ucss_defs.svh"
module ucss_core #(
   parameter int DIV_W = 16
) (
   // clock, reset, enable
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   // avalon-mm slave
   input wire logic [`UCSS_ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // serial pins
   input wire logic i_rxd,
   output logic o_txd,
   // interrupt and channel state
   output logic o_irq,
   output logic [1:0] o_operating
);
   // bus and control state
   logic rd_ack_reg, rd_ack_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] op_reg, op_next;
   logic [2:0] ctrl_reg, ctrl_next;
   logic [DIV_W-1:0] div_reg, div_next;
   logic [2:0] irq_st_reg, irq_st_next;
   logic [2:0] irq_msk_reg, irq_msk_next;
   logic wr_en, rd_take;
   logic [7:0] wbyte;
   logic [31:0] rmux;
   // transmit state
   ucss_pkg::ucss_ser_state_t tx_st_reg, tx_st_next;
   logic [DIV_W-1:0] tx_cnt_reg, tx_cnt_next;
   logic [7:0] tx_sh_reg, tx_sh_next;
   logic [7:0] tx_buf_reg, tx_buf_next;
   logic [2:0] tx_bit_reg, tx_bit_next;
   logic tx_bff_reg, tx_bff_next;
   logic tx_par_reg, tx_par_next;
   logic txd_reg, txd_next;
   logic ev_tx;
   // receive state
   ucss_pkg::ucss_ser_state_t rx_st_reg, rx_st_next;
   logic [DIV_W-1:0] rx_cnt_reg, rx_cnt_next;
   logic [7:0] rx_sh_reg, rx_sh_next;
   logic [7:0] rx_data_reg, rx_data_next;
   logic [2:0] rx_bit_reg, rx_bit_next;
   logic rx_full_reg, rx_full_next;
   logic rx_par_reg, rx_par_next;
   logic fef_reg, fef_next;
   logic pef_reg, pef_next;
   logic ovf_reg, ovf_next;
   logic ev_rx, ev_err;
   ucss_pkg::ucss_status_t tx_status, rx_status;

   // bus strobes
   assign o_avs_waitrequest = ~i_clk_en | (i_avs_read & ~rd_ack_reg);
   assign wr_en = i_clk_en & i_avs_write & i_avs_byteenable[0];
   assign rd_take = i_clk_en & i_avs_read & rd_ack_reg;
   assign wbyte = i_avs_writedata[7:0];
   assign o_avs_readdata = rdata_reg;
   assign o_txd = txd_reg;
   assign o_operating = op_reg;
   assign o_irq = |(irq_st_reg & irq_msk_reg);

   always_comb begin
      tx_status = '0;
      tx_status.tsf = (tx_st_reg != ucss_pkg::SER_IDLE);
      tx_status.bff = tx_bff_reg;
      rx_status = '0;
      rx_status.tsf = (rx_st_reg != ucss_pkg::SER_IDLE);
      rx_status.bff = rx_full_reg;
      rx_status.fef = fef_reg;
      rx_status.pef = pef_reg;
      rx_status.ovf = ovf_reg;
   end

   always_comb begin
      rmux = '0;
      unique case (i_avs_address)
         `UCSS_OFS_TXST: rmux[7:0] = tx_status;
         `UCSS_OFS_TXDATA: rmux[7:0] = tx_buf_reg;
         `UCSS_OFS_RXST: rmux[7:0] = rx_status;
         `UCSS_OFS_RXDATA: rmux[7:0] = rx_data_reg;
         `UCSS_OFS_CTRL: rmux[2:0] = ctrl_reg;
         `UCSS_OFS_DIV: rmux[DIV_W-1:0] = div_reg;
         `UCSS_OFS_IRQST: rmux[2:0] = irq_st_reg;
         `UCSS_OFS_IRQMSK: rmux[2:0] = irq_msk_reg;
         `UCSS_OFS_OPFLAG: rmux[1:0] = op_reg;
         default: rmux = '0;
      endcase
   end

   // bus, control and interrupt next values
   always_comb begin
      rd_ack_next = i_avs_read & ~rd_ack_reg;
      rdata_next = rdata_reg;
      op_next = op_reg;
      ctrl_next = ctrl_reg;
      div_next = div_reg;
      irq_msk_next = irq_msk_reg;
      irq_st_next = irq_st_reg;
      if (i_avs_read & ~rd_ack_reg) begin
         rdata_next = rmux;
      end
      if (wr_en) begin
         unique case (i_avs_address)
            `UCSS_OFS_START: begin
               op_next = op_reg | wbyte[1:0];
            end
            `UCSS_OFS_STOP: begin
               op_next = op_reg & ~wbyte[1:0];
            end
            `UCSS_OFS_CTRL: ctrl_next = wbyte[2:0];
            `UCSS_OFS_DIV: div_next = i_avs_writedata[DIV_W-1:0];
            `UCSS_OFS_IRQMSK: irq_msk_next = wbyte[2:0];
            default: begin
            end
         endcase
      end
      if (rd_take && i_avs_address == `UCSS_OFS_IRQST) begin
         irq_st_next = '0;
      end
      irq_st_next[`UCSS_IRQ_TXDONE] = irq_st_next[`UCSS_IRQ_TXDONE] | ev_tx;
      irq_st_next[`UCSS_IRQ_RXDONE] = irq_st_next[`UCSS_IRQ_RXDONE] | ev_rx;
      irq_st_next[`UCSS_IRQ_RXERR] = irq_st_next[`UCSS_IRQ_RXERR] | ev_err;
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         rd_ack_reg <= 1'b0;
         rdata_reg <= '0;
         op_reg <= '0;
         ctrl_reg <= '0;
         div_reg <= DIV_W'(`UCSS_DIV_RST);
         irq_st_reg <= '0;
         irq_msk_reg <= '0;
      end else if (i_clk_en) begin
         rd_ack_reg <= rd_ack_next;
         rdata_reg <= rdata_next;
         op_reg <= op_next;
         ctrl_reg <= ctrl_next;
         div_reg <= div_next;
         irq_st_reg <= irq_st_next;
         irq_msk_reg <= irq_msk_next;
      end
   end

   // transmit channel next values
   always_comb begin
      tx_st_next = tx_st_reg;
      tx_cnt_next = tx_cnt_reg;
      tx_sh_next = tx_sh_reg;
      tx_buf_next = tx_buf_reg;
      tx_bit_next = tx_bit_reg;
      tx_bff_next = tx_bff_reg;
      tx_par_next = tx_par_reg;
      txd_next = txd_reg;
      ev_tx = 1'b0;
      if (op_reg[`UCSS_CH_TX]) begin
         unique case (tx_st_reg)
            ucss_pkg::SER_IDLE: begin
               if (tx_bff_reg) begin
                  tx_sh_next = tx_buf_reg;
                  tx_par_next = ^tx_buf_reg ^ ctrl_reg[`UCSS_CTRL_PARODD];
                  tx_bff_next = 1'b0;
                  txd_next = 1'b0;
                  tx_cnt_next = div_reg;
                  tx_st_next = ucss_pkg::SER_START;
               end
            end
            default: begin
               if (tx_cnt_reg != '0) begin
                  tx_cnt_next = tx_cnt_reg - 1'b1;
               end else begin
                  tx_cnt_next = div_reg;
                  unique case (tx_st_reg)
                     ucss_pkg::SER_START: begin
                        txd_next = tx_sh_reg[0];
                        tx_bit_next = '0;
                        tx_st_next = ucss_pkg::SER_DATA;
                     end
                     ucss_pkg::SER_DATA: begin
                        if (tx_bit_reg == `UCSS_LAST_BIT) begin
                           if (ctrl_reg[`UCSS_CTRL_PAREN]) begin
                              txd_next = tx_par_reg;
                              tx_st_next = ucss_pkg::SER_PAR;
                           end else begin
                              txd_next = 1'b1;
                              tx_st_next = ucss_pkg::SER_STOP;
                           end
                        end else begin
                           tx_sh_next = {1'b0, tx_sh_reg[7:1]};
                           txd_next = tx_sh_reg[1];
                           tx_bit_next = tx_bit_reg + 1'b1;
                        end
                     end
                     ucss_pkg::SER_PAR: begin
                        txd_next = 1'b1;
                        tx_st_next = ucss_pkg::SER_STOP;
                     end
                     default: begin
                        ev_tx = 1'b1;
                        tx_st_next = ucss_pkg::SER_IDLE;
                     end
                  endcase
               end
            end
         endcase
      end
      if (wr_en && i_avs_address == `UCSS_OFS_TXDATA) begin
         tx_buf_next = wbyte;
         tx_bff_next = 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         tx_st_reg <= ucss_pkg::SER_IDLE;
         tx_cnt_reg <= '0;
         tx_sh_reg <= '0;
         tx_buf_reg <= '0;
         tx_bit_reg <= '0;
         tx_bff_reg <= 1'b0;
         tx_par_reg <= 1'b0;
         txd_reg <= 1'b1;
      end else if (i_clk_en) begin
         tx_st_reg <= tx_st_next;
         tx_cnt_reg <= tx_cnt_next;
         tx_sh_reg <= tx_sh_next;
         tx_buf_reg <= tx_buf_next;
         tx_bit_reg <= tx_bit_next;
         tx_bff_reg <= tx_bff_next;
         tx_par_reg <= tx_par_next;
         txd_reg <= txd_next;
      end
   end

   // receive channel next values
   always_comb begin
      rx_st_next = rx_st_reg;
      rx_cnt_next = rx_cnt_reg;
      rx_sh_next = rx_sh_reg;
      rx_data_next = rx_data_reg;
      rx_bit_next = rx_bit_reg;
      rx_full_next = rx_full_reg;
      rx_par_next = rx_par_reg;
      fef_next = fef_reg;
      pef_next = pef_reg;
      ovf_next = ovf_reg;
      ev_rx = 1'b0;
      ev_err = 1'b0;
      if (rd_take && i_avs_address == `UCSS_OFS_RXDATA) begin
         rx_full_next = 1'b0;
      end
      if (wr_en && i_avs_address == `UCSS_OFS_ERRCLR) begin
         if (wbyte[`UCSS_CLR_FE]) begin
            fef_next = 1'b0;
         end
         if (wbyte[`UCSS_CLR_PE]) begin
            pef_next = 1'b0;
         end
         if (wbyte[`UCSS_CLR_OV]) begin
            ovf_next = 1'b0;
         end
      end
      if (op_reg[`UCSS_CH_RX] & ctrl_reg[`UCSS_CTRL_RXE]) begin
         unique case (rx_st_reg)
            ucss_pkg::SER_IDLE: begin
               if (!i_rxd) begin
                  rx_cnt_next = div_reg >> 1;
                  rx_st_next = ucss_pkg::SER_START;
               end
            end
            default: begin
               if (rx_cnt_reg != '0) begin
                  rx_cnt_next = rx_cnt_reg - 1'b1;
               end else begin
                  rx_cnt_next = div_reg;
                  unique case (rx_st_reg)
                     ucss_pkg::SER_START: begin
                        rx_bit_next = '0;
                        rx_par_next = ctrl_reg[`UCSS_CTRL_PARODD];
                        rx_st_next = i_rxd ? ucss_pkg::SER_IDLE : ucss_pkg::SER_DATA;
                     end
                     ucss_pkg::SER_DATA: begin
                        rx_sh_next = {i_rxd, rx_sh_reg[7:1]};
                        rx_par_next = rx_par_reg ^ i_rxd;
                        rx_bit_next = rx_bit_reg + 1'b1;
                        if (rx_bit_reg == `UCSS_LAST_BIT) begin
                           rx_st_next = ctrl_reg[`UCSS_CTRL_PAREN] ? ucss_pkg::SER_PAR : ucss_pkg::SER_STOP;
                        end
                     end
                     ucss_pkg::SER_PAR: begin
                        if (rx_par_reg ^ i_rxd) begin
                           pef_next = 1'b1;
                           ev_err = 1'b1;
                        end
                        rx_st_next = ucss_pkg::SER_STOP;
                     end
                     default: begin
                        if (!i_rxd) begin
                           fef_next = 1'b1;
                           ev_err = 1'b1;
                        end
                        if (rx_full_next) begin
                           ovf_next = 1'b1;
                           ev_err = 1'b1;
                        end
                        rx_data_next = rx_sh_reg;
                        rx_full_next = 1'b1;
                        ev_rx = 1'b1;
                        rx_st_next = ucss_pkg::SER_IDLE;
                     end
                  endcase
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         rx_st_reg <= ucss_pkg::SER_IDLE;
         rx_cnt_reg <= '0;
         rx_sh_reg <= '0;
         rx_data_reg <= '0;
         rx_bit_reg <= '0;
         rx_full_reg <= 1'b0;
         rx_par_reg <= 1'b0;
         fef_reg <= 1'b0;
         pef_reg <= 1'b0;
         ovf_reg <= 1'b0;
      end else if (i_clk_en) begin
         rx_st_reg <= rx_st_next;
         rx_cnt_reg <= rx_cnt_next;
         rx_sh_reg <= rx_sh_next;
         rx_data_reg <= rx_data_next;
         rx_bit_reg <= rx_bit_next;
         rx_full_reg <= rx_full_next;
         rx_par_reg <= rx_par_next;
         fef_reg <= fef_next;
         pef_reg <= pef_next;
         ovf_reg <= ovf_next;
      end
   end
endmodule : ucss_core

// ==== design/ucss_defs.svh ====
// register offsets, bit positions and reset values of the serial channel block
`ifndef UCSS_DEFS_SVH
`define UCSS_DEFS_SVH
`define UCSS_ADDR_W 6
`define UCSS_OFS_START 6'h00
`define UCSS_OFS_STOP 6'h04
`define UCSS_OFS_TXST 6'h08
`define UCSS_OFS_TXDATA 6'h0C
`define UCSS_OFS_RXST 6'h10
`define UCSS_OFS_RXDATA 6'h14
`define UCSS_OFS_ERRCLR 6'h18
`define UCSS_OFS_CTRL 6'h1C
`define UCSS_OFS_DIV 6'h20
`define UCSS_OFS_IRQST 6'h24
`define UCSS_OFS_IRQMSK 6'h28
`define UCSS_OFS_OPFLAG 6'h2C
`define UCSS_CH_TX 0
`define UCSS_CH_RX 1
`define UCSS_CLR_FE 2
`define UCSS_CLR_PE 1
`define UCSS_CLR_OV 0
`define UCSS_CTRL_RXE 0
`define UCSS_CTRL_PAREN 1
`define UCSS_CTRL_PARODD 2
`define UCSS_IRQ_TXDONE 0
`define UCSS_IRQ_RXDONE 1
`define UCSS_IRQ_RXERR 2
`define UCSS_DIV_RST 16'h01B2
`define UCSS_LAST_BIT 3'h7
`endif

// ==== design/ucss_pkg.sv ====
// types shared by the serial channel block
package ucss_pkg;
   typedef struct packed {
      logic zero7;
      logic tsf;
      logic bff;
      logic [1:0] zero43;
      logic fef;
      logic pef;
      logic ovf;
   } ucss_status_t;
   typedef enum logic [2:0] {
      SER_IDLE,
      SER_START,
      SER_DATA,
      SER_PAR,
      SER_STOP
   } ucss_ser_state_t;
endpackage : ucss_pkg

// ==== verif/test_ucss_core.sv ====
// self-checking bench for the serial channel block
`include "ucss_defs.svh"
module test_ucss_core;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {
      logic rd;
      logic [5:0] a;
      logic [7:0] d;
      logic [3:0] be;
      logic [7:0] q;
      logic [1:0] op;
   } ucss_row_t;
   logic sys_clk = 1'h0, sys_rst = 1'h1, clk_en = 1'h1, avs_read = 1'h0, avs_write = 1'h0;
   logic [5:0] avs_address = 6'h00;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'h0;
   logic [31:0] avs_readdata, q;
   logic avs_waitrequest, rxd, txd, irq, t0;
   logic [1:0] op;
   logic [7:0] rx_byte, rx_count;
   int miscompares = 0;
   int n_checks = 0;
   int n;
   ucss_row_t rows[12] = '{
      '{1'h0, `UCSS_OFS_START, 8'h00, 4'h1, 8'h00, 2'h0}, '{1'h0, `UCSS_OFS_START, 8'h01, 4'h0, 8'h00, 2'h0},
      '{1'h0, `UCSS_OFS_START, 8'h01, 4'h1, 8'h00, 2'h1}, '{1'h0, `UCSS_OFS_START, 8'h02, 4'h1, 8'h00, 2'h3},
      '{1'h0, `UCSS_OFS_STOP, 8'h00, 4'h1, 8'h00, 2'h3}, '{1'h0, `UCSS_OFS_STOP, 8'h01, 4'h1, 8'h00, 2'h2},
      '{1'h0, `UCSS_OFS_STOP, 8'h02, 4'h1, 8'h00, 2'h0}, '{1'h0, `UCSS_OFS_START, 8'hFC, 4'h1, 8'h00, 2'h0},
      '{1'h1, `UCSS_OFS_START, 8'h00, 4'hF, 8'h00, 2'h0}, '{1'h1, `UCSS_OFS_STOP, 8'h00, 4'hF, 8'h00, 2'h0},
      '{1'h1, `UCSS_OFS_TXST, 8'h00, 4'hF, 8'h00, 2'h0}, '{1'h1, 6'h3C, 8'h00, 4'hF, 8'h00, 2'h0}};
   always #10 sys_clk = ~sys_clk;
   ucss_core i_ucss_core (.i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_clk_en(clk_en), .i_avs_address(avs_address),
      .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
      .i_avs_byteenable(avs_byteenable), .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
      .i_rxd(rxd), .o_txd(txd), .o_irq(irq), .o_operating(op));
   ucss_remote #(.BIT_CYC(4)) i_ucss_remote (.i_sys_clk(sys_clk), .i_txd(txd), .o_rxd(rxd), .o_rx_byte(rx_byte),
      .o_rx_count(rx_count));
   task automatic summarize();
      if (miscompares == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize
   task automatic hang();
      miscompares++;
      $display("[ERR] %0t wait limit reached", $time);
      summarize();
   endtask : hang
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic rd, input logic [5:0] a, input logic [7:0] d, input logic [3:0] be);
      int k;
      k = 0;
      avs_address <= a;
      avs_writedata <= {24'h00_0000, d};
      avs_byteenable <= be;
      avs_read <= rd;
      avs_write <= !rd;
      do begin
         @(posedge sys_clk);
         k++;
      end while (avs_waitrequest !== 1'h0 && k < 50);
      q = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      if (k >= 50) hang();
      @(posedge sys_clk);
   endtask : bus
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      bus(1'h0, a, d, 4'h1);
   endtask : wr
   task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
      bus(1'h1, a, 8'h00, 4'hF);
      chk(q, {24'h00_0000, e});
   endtask : rd_chk
   initial begin
      repeat (3) @(posedge sys_clk);
      sys_rst <= 1'h0;
      foreach (rows[i]) begin
         bus(rows[i].rd, rows[i].a, rows[i].d, rows[i].be);
         if (rows[i].rd) chk(q, {24'h00_0000, rows[i].q});
         chk({30'h0000_0000, op}, {30'h0000_0000, rows[i].op});
      end
      wr(`UCSS_OFS_DIV, 8'h03);
      wr(`UCSS_OFS_TXDATA, 8'hA5);
      rd_chk(`UCSS_OFS_TXST, 8'h20);
      wr(`UCSS_OFS_START, 8'h01);
      rd_chk(`UCSS_OFS_OPFLAG, 8'h01);
      rd_chk(`UCSS_OFS_TXST, 8'h40);
      n = 0;
      while (rx_count !== 8'h01 && n < 400) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 400) hang();
      chk({24'h00_0000, rx_byte}, 32'h0000_00A5);
      wr(`UCSS_OFS_TXDATA, 8'h3C);
      repeat (12) @(posedge sys_clk);
      wr(`UCSS_OFS_STOP, 8'h01);
      t0 = txd;
      repeat (16) @(posedge sys_clk);
      chk({31'h0000_0000, txd}, {31'h0000_0000, t0});
      rd_chk(`UCSS_OFS_TXST, 8'h40);
      wr(`UCSS_OFS_START, 8'h01);
      rd_chk(`UCSS_OFS_IRQST, 8'h01);
      wr(`UCSS_OFS_IRQMSK, 8'h02);
      wr(`UCSS_OFS_CTRL, 8'h01);
      repeat (4) @(posedge sys_clk);
      wr(`UCSS_OFS_START, 8'h02);
      i_ucss_remote.send_byte(8'h5A, 1'h0, 1'h0, 1'h1);
      chk({31'h0000_0000, irq}, 32'h0000_0001);
      rd_chk(`UCSS_OFS_IRQST, 8'h03);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      rd_chk(`UCSS_OFS_RXST, 8'h20);
      rd_chk(`UCSS_OFS_RXDATA, 8'h5A);
      wr(`UCSS_OFS_CTRL, 8'h03);
      i_ucss_remote.send_byte(8'h81, 1'h1, 1'h1, 1'h1);
      bus(1'h1, `UCSS_OFS_RXDATA, 8'h00, 4'hF);
      i_ucss_remote.send_byte(8'h11, 1'h1, 1'h0, 1'h1);
      i_ucss_remote.send_byte(8'h22, 1'h1, 1'h0, 1'h1);
      wr(`UCSS_OFS_STOP, 8'h02);
      rd_chk(`UCSS_OFS_RXST, 8'h23);
      wr(`UCSS_OFS_ERRCLR, 8'h04);
      rd_chk(`UCSS_OFS_RXST, 8'h23);
      wr(`UCSS_OFS_ERRCLR, 8'h02);
      rd_chk(`UCSS_OFS_RXST, 8'h21);
      wr(`UCSS_OFS_ERRCLR, 8'h01);
      rd_chk(`UCSS_OFS_RXST, 8'h20);
      // clock enable low freezes a started frame
      wr(`UCSS_OFS_TXDATA, 8'hFF);
      clk_en <= 1'h0;
      repeat (20) @(posedge sys_clk);
      chk({31'h0000_0000, txd}, 32'h0000_0000);
      chk({31'h0000_0000, avs_waitrequest}, 32'h0000_0001);
      clk_en <= 1'h1;
      rd_chk(`UCSS_OFS_TXST, 8'h40);
      // second reset in mid-frame
      sys_rst <= 1'h1;
      repeat (3) @(posedge sys_clk);
      sys_rst <= 1'h0;
      chk({30'h0000_0000, op}, 32'h0000_0000);
      chk({31'h0000_0000, txd}, 32'h0000_0001);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      bus(1'h1, `UCSS_OFS_DIV, 8'h00, 4'hF);
      chk(q, {16'h0000, `UCSS_DIV_RST});
      rd_chk(`UCSS_OFS_RXST, 8'h00);
      rd_chk(`UCSS_OFS_TXST, 8'h00);
      summarize();
   end
endmodule : test_ucss_core

// ==== verif/ucss_core_props.sv ====
// port assertions for the serial channel block
`include "ucss_defs.svh"
module ucss_core_props (
   // clock, reset, enable
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   // register bus
   input wire logic [`UCSS_ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   // pins and flags
   input wire logic i_rxd,
   input wire logic o_txd,
   input wire logic o_irq,
   input wire logic [1:0] o_operating
);
   timeunit 1ns;
   timeprecision 1ns;
   logic wr_go, wr_start, wr_stop, rd_done;
   assign wr_go = i_avs_write && i_clk_en && i_avs_byteenable[0];
   assign wr_start = wr_go && i_avs_address == `UCSS_OFS_START;
   assign wr_stop = wr_go && i_avs_address == `UCSS_OFS_STOP;
   assign rd_done = i_avs_read && !o_avs_waitrequest;
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_sys_rst);
   a_start_tx: assert property (wr_start && i_avs_writedata[0] |=> o_operating[0])
      else $error("start write left tx flag low");
   a_start_rx: assert property (wr_start && i_avs_writedata[1] |=> o_operating[1])
      else $error("start write left rx flag low");
   a_stop_tx: assert property (wr_stop && i_avs_writedata[0] |=> !o_operating[0])
      else $error("stop write left tx flag high");
   a_stop_rx: assert property (wr_stop && i_avs_writedata[1] |=> !o_operating[1])
      else $error("stop write left rx flag high");
   a_zero_keeps: assert property ((wr_start || wr_stop) && i_avs_writedata[1:0] == 2'h0 |=> $stable(o_operating))
      else $error("zero trigger changed a flag");
   a_stop_freeze: assert property (!o_operating[0] && !wr_start |=> $stable(o_txd))
      else $error("stopped channel moved its data pin");
   a_status_layout: assert property (rd_done && i_avs_address == `UCSS_OFS_TXST |-> o_avs_readdata[31:7] == '0 && o_avs_readdata[4:0] == '0)
      else $error("tx status has bits outside its fields");
   a_trig_read: assert property (rd_done && (wr_start || i_avs_address inside {`UCSS_OFS_START, `UCSS_OFS_STOP}) |-> o_avs_readdata == '0)
      else $error("trigger register read not zero");
   cover property (wr_start && i_avs_writedata[1:0] == 2'h3);
   cover property (wr_stop && i_avs_writedata[0] && o_operating[0]);
   cover property (rd_done && i_avs_address == `UCSS_OFS_TXST && o_avs_readdata[5]);
endmodule : ucss_core_props
bind ucss_core ucss_core_props i_ucss_core_props (.i_sys_clk, .i_sys_rst, .i_clk_en, .i_avs_address, .i_avs_read,
   .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_rxd, .o_txd, .o_irq,
   .o_operating);

// ==== verif/ucss_remote.sv ====
// remote serial device: sends frames to the block and collects its frames
module ucss_remote #(
   parameter int BIT_CYC = 4
) (
   // clock
   input wire logic i_sys_clk,
   // serial lines
   input wire logic i_txd,
   output logic o_rxd,
   // collected data
   output logic [7:0] o_rx_byte,
   output logic [7:0] o_rx_count
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_rxd = 1'h1;
      o_rx_count = 8'h00;
      o_rx_byte = 8'h00;
   end
   // collect a frame lsb first, sampled mid bit
   always begin
      @(negedge i_txd);
      repeat (BIT_CYC / 2) @(posedge i_sys_clk);
      for (int i = 0; i < 9; i++) begin
         repeat (BIT_CYC) @(posedge i_sys_clk);
         if (i < 8) o_rx_byte[i] <= i_txd;
      end
      o_rx_count <= o_rx_count + 8'h01;
   end
   // send a frame; bad parity or stop level only on request
   task automatic send_byte(input logic [7:0] data, input logic par_en, input logic par_bad, input logic stop_lvl);
      logic [10:0] frame;
      frame = {stop_lvl, ^data ^ par_bad, data, 1'h0};
      if (!par_en) frame[9] = stop_lvl;
      for (int i = 0; i < (par_en ? 11 : 10); i++) begin
         @(posedge i_sys_clk);
         o_rxd <= frame[i];
         repeat (BIT_CYC - 1) @(posedge i_sys_clk);
      end
      @(posedge i_sys_clk);
      o_rxd <= 1'h1;
   endtask : send_byte
endmodule : ucss_remote
